// [common/lpmc_defs.svh]
// Constants for the low-power mode controller: register offsets, fields, timing.
// Assumes inclusion by bare name from design files.
`ifndef LPMC_DEFS_SVH
`define LPMC_DEFS_SVH

`define LPMC_PMC_IDX        8'h87
`define LPMC_PMC_ADDR       10'h21c
`define LPMC_STAT_ADDR      10'h220
`define LPMC_PMC_RST        8'h00
`define LPMC_BIT_IDLE       0
`define LPMC_BIT_PD         1
`define LPMC_SETTLE_NS      1000
`define LPMC_CLK_NS         10
`define LPMC_SETTLE_CYC     ((`LPMC_SETTLE_NS + `LPMC_CLK_NS - 1) / `LPMC_CLK_NS)

`endif

// [common/lpmc_pkg.sv]
// Types for the low-power mode controller.
// Assumes no other package.
package lpmc_pkg;
	typedef enum logic [1:0] {
		LPMC_RUN,
		LPMC_IDLE,
		LPMC_PDOWN,
		LPMC_SETTLE
	} lpmc_state_t;
endpackage

// [hdl/lpmc_ctrl.sv]
// Low-power mode controller: idle and power-down sequencing with wake logic.
// Assumes classic Wishbone master on clk_i, wake sources on clk_i except pins.
//
// What this block does
// (R01) Clear watchdog on sleep entry and wake
// (R02) Power-down bit stops CPU and peripheral clocks
// (R03) Power-down wake clears bit, handler, resume
// (R04) Both bits set: power-down only, no idle
// (R05) Idle bit stops only CPU clock
// (R06) Idle wake clears bit, handler, resume
// (R07) Idle freezes CPU state and port levels
// (R08) Idle write is last instruction before idle
// (R09) Any enabled interrupt ends idle
// (R10) Non-software resets end idle
// (R11) Power-down halts clock whatever its source
// (R12) Power-down write last; RAM, pins kept
// (R13) Non-software resets end power-down
// (R14) Pin or power-on reset restarts program
// (R15) External pin wakes if enabled and global
// (R16) Supply-drop, watchdog, keypad interrupts also wake
// (R17) Keypad wakes on edge opposite entry level
// (R18) Software enables supply-drop detector before entry
// (R19) Hold CPU until restarted clock has settled
`timescale 1ns/1ns
`include "lpmc_defs.svh"

module lpmc_ctrl (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic [31:0] wb_adr_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic        wb_we_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	output logic             wb_ack_o,
	input  wire logic        global_interrupt_enable_i,
	input  wire logic [1:0]  ext_int_en_i,
	input  wire logic [1:0]  ext_int_pin_i,
	input  wire logic        enabled_irq_pending_i,
	input  wire logic        supply_drop_irq_i,
	input  wire logic        watchdog_irq_i,
	input  wire logic        pin_change_keypad_en_i,
	input  wire logic [7:0]  pin_change_keypad_i,
	input  wire logic        hw_reset_i,
	input  wire logic        full_init_reset_i,
	output logic             cpu_clk_en_o,
	output logic             periph_clk_en_o,
	output logic             osc_run_o,
	output logic             cpu_hold_o,
	output logic             watchdog_counter_clr_o,
	output logic             port_freeze_o,
	output logic             cpu_full_init_o
);

	logic [7:0]              pmc_q, pmc_d;
	lpmc_pkg::lpmc_state_t   st_q, st_d;
	logic [7:0]              settle_q, settle_d;
	logic                    wdc_q, wdc_d;
	logic                    ack_q;
	logic [31:0]             rdat_q;
	logic                    finit_q;
	logic [1:0]              ext_s1_q, ext_s2_q;
	logic [7:0]              kp_s1_q, kp_s2_q, kp_ref_q;

	function automatic logic wb_hit(input logic [31:0] adr, input logic [9:0] off);
		wb_hit = (adr[9:2] == off[9:2]) && (adr[31:10] == 22'h0);
	endfunction

	// Bus decode
	wire bus_req   = wb_cyc_i && wb_stb_i && !ack_q;
	wire hit_pmc   = wb_hit(wb_adr_i, `LPMC_PMC_ADDR);
	wire hit_stat  = wb_hit(wb_adr_i, `LPMC_STAT_ADDR);
	wire wr_pmc    = bus_req && wb_we_i && hit_pmc && wb_sel_i[0];
	wire [7:0] wr_val = wb_dat_i[7:0];
	wire wr_pd     = wr_pmc && wr_val[`LPMC_BIT_PD];
	wire wr_idle   = wr_pmc && wr_val[`LPMC_BIT_IDLE];

	// Wake sources
	wire ext_wake  = global_interrupt_enable_i && |(ext_int_en_i & ext_s2_q); // [R15]
	wire kp_wake   = pin_change_keypad_en_i && |(kp_s2_q ^ kp_ref_q);         // [R17]
	wire pd_wake   = ext_wake || kp_wake || supply_drop_irq_i || watchdog_irq_i; // [R16]
	wire idle_wake = enabled_irq_pending_i;                                   // [R09]

	wire in_run    = (st_q == lpmc_pkg::LPMC_RUN);
	wire in_idle   = (st_q == lpmc_pkg::LPMC_IDLE);
	wire in_pd     = (st_q == lpmc_pkg::LPMC_PDOWN);
	wire in_settle = (st_q == lpmc_pkg::LPMC_SETTLE);
	wire settled   = (settle_q == 8'h00);

	always_comb begin
		st_d     = st_q;
		pmc_d    = pmc_q;
		settle_d = settle_q;
		wdc_d    = 1'b0;
		if (wr_pmc)
			pmc_d = wr_val;
		case (st_q)
			lpmc_pkg::LPMC_RUN: begin
				if (wr_pd) begin                                   // [R02] [R04]
					st_d  = lpmc_pkg::LPMC_PDOWN;
					wdc_d = 1'b1;                                  // [R01]
				end else if (wr_idle) begin                        // [R05]
					st_d  = lpmc_pkg::LPMC_IDLE;
					wdc_d = 1'b1;                                  // [R01]
				end
			end
			lpmc_pkg::LPMC_IDLE: begin
				if (idle_wake) begin                               // [R06]
					st_d  = lpmc_pkg::LPMC_RUN;
					pmc_d[`LPMC_BIT_IDLE] = 1'b0;
					wdc_d = 1'b1;                                  // [R01]
				end
			end
			lpmc_pkg::LPMC_PDOWN: begin
				if (pd_wake) begin                                 // [R03]
					st_d     = lpmc_pkg::LPMC_SETTLE;
					settle_d = 8'(`LPMC_SETTLE_CYC - 1);          // [R19]
				end
			end
			lpmc_pkg::LPMC_SETTLE: begin
				if (settled) begin
					st_d  = lpmc_pkg::LPMC_RUN;
					// Idle bit also dropped so no idle after power-down
					pmc_d[`LPMC_BIT_PD]   = 1'b0;                  // [R03] [R04]
					pmc_d[`LPMC_BIT_IDLE] = 1'b0;
					wdc_d = 1'b1;                                  // [R01]
				end else begin
					settle_d = settle_q - 8'h01;
				end
			end
			default: st_d = lpmc_pkg::LPMC_RUN;
		endcase
		// Hardware resets end any low-power state
		if (hw_reset_i) begin                                      // [R10] [R13]
			st_d  = lpmc_pkg::LPMC_RUN;
			pmc_d = `LPMC_PMC_RST;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			st_q <= lpmc_pkg::LPMC_RUN;
		else
			st_q <= st_d;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			pmc_q <= `LPMC_PMC_RST;
		else
			pmc_q <= pmc_d;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			settle_q <= 8'h00;
		else
			settle_q <= settle_d;
	end

	// One-cycle watchdog clear pulse
	always_ff @(posedge clk_i) begin
		if (rst_i)
			wdc_q <= 1'b0;
		else
			wdc_q <= wdc_d;
	end

	// External interrupt pin synchroniser
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ext_s1_q <= 2'h0;
			ext_s2_q <= 2'h0;
		end else begin
			ext_s1_q <= ext_int_pin_i;
			ext_s2_q <= ext_s1_q;
		end
	end

	// Keypad pin synchroniser
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			kp_s1_q <= 8'h00;
			kp_s2_q <= 8'h00;
		end else begin
			kp_s1_q <= pin_change_keypad_i;
			kp_s2_q <= kp_s1_q;
		end
	end

	// Keypad level captured at entry; wake on the opposite level
	always_ff @(posedge clk_i) begin
		if (rst_i)
			kp_ref_q <= 8'h00;
		else if (!in_pd)
			kp_ref_q <= kp_s2_q;                                   // [R17]
	end

	// Full initialisation request after pin or power-on reset
	always_ff @(posedge clk_i) begin
		if (rst_i)
			finit_q <= 1'b0;
		else
			finit_q <= full_init_reset_i;                          // [R14]
	end

	// Wishbone slave: one wait state, unmapped reads zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q  <= 1'b0;
			rdat_q <= 32'h0;
		end else begin
			ack_q  <= bus_req;
			if (bus_req && !wb_we_i)
				rdat_q <= hit_pmc ? {24'h0, pmc_q} :
					hit_stat ? {28'h0, settle_q == 8'h00, in_settle, in_pd, in_idle} :
					32'h0;
		end
	end

	assign wb_ack_o               = ack_q;
	assign wb_dat_o               = rdat_q;
	assign cpu_clk_en_o           = in_run;                        // [R05] [R08] [R12]
	assign periph_clk_en_o        = !(in_pd || in_settle);         // [R02] [R11]
	assign osc_run_o              = !in_pd;                        // [R11] [R15]
	assign cpu_hold_o             = !in_run;                       // [R07] [R19]
	assign port_freeze_o          = !in_run;                       // [R07] [R12]
	assign watchdog_counter_clr_o = wdc_q;
	assign cpu_full_init_o        = finit_q;

	// Checks
	chk_pd_entry_wdc: assert property (@(posedge clk_i) disable iff (rst_i) // [R01]
		(in_run && wr_pd && !hw_reset_i) |=> (in_pd && watchdog_counter_clr_o))
		else $error("power-down entry without watchdog clear");
	chk_both_pd_only: assert property (@(posedge clk_i) disable iff (rst_i) // [R04]
		(in_run && wr_pd && wr_idle && !hw_reset_i) |=> (in_pd && !in_idle))
		else $error("idle entered with power-down request");
	chk_idle_clk: assert property (@(posedge clk_i) disable iff (rst_i) // [R05]
		in_idle |-> (!cpu_clk_en_o && periph_clk_en_o))
		else $error("idle clocks wrong");
	chk_pd_clk: assert property (@(posedge clk_i) disable iff (rst_i) // [R02]
		in_pd |-> (!cpu_clk_en_o && !periph_clk_en_o && !osc_run_o))
		else $error("power-down clocks wrong");
	chk_idle_wake: assert property (@(posedge clk_i) disable iff (rst_i) // [R06]
		(in_idle && idle_wake && !hw_reset_i) |=>
		((in_run && !pmc_q[`LPMC_BIT_IDLE] && watchdog_counter_clr_o) ##1
		!watchdog_counter_clr_o))
		else $error("idle wake wrong");
	sequence s_pd_wake;
		in_pd && pd_wake && !hw_reset_i;
	endsequence
	chk_pd_settle: assert property (@(posedge clk_i) disable iff (rst_i || hw_reset_i) // [R19]
		s_pd_wake |=> cpu_hold_o [*8] ##[1:200] (in_run && !pmc_q[`LPMC_BIT_PD]))
		else $error("power-down wake did not settle");
	chk_reset_exit: assert property (@(posedge clk_i) disable iff (rst_i) // [R13]
		hw_reset_i |=> (in_run && pmc_q == `LPMC_PMC_RST))
		else $error("reset did not end low-power state");
	chk_ext_gate: assert property (@(posedge clk_i) disable iff (rst_i) // [R15]
		(in_pd && !global_interrupt_enable_i && !kp_wake && !supply_drop_irq_i
		&& !watchdog_irq_i && !hw_reset_i) |=> in_pd)
		else $error("wake without enabled source");
	chk_bus_ack: assert property (@(posedge clk_i) disable iff (rst_i)
		(wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
		else $error("bus ack late");
	chk_ack_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
		wb_ack_o |=> !wb_ack_o)
		else $error("bus ack longer than one cycle");

	// Entry and exit steps
	sequence s_idle_entry;
		in_run && wr_idle && !wr_pd && !hw_reset_i;
	endsequence
	sequence s_pd_entry;
		in_run && wr_pd && !hw_reset_i;
	endsequence
	sequence s_settle_done;
		in_settle && settled && !hw_reset_i;
	endsequence

	chk_idle_entry_wdc: assert property (@(posedge clk_i) disable iff (rst_i) // [R01]
		s_idle_entry |=> (in_idle && watchdog_counter_clr_o))
		else $error("idle entry without watchdog clear");
	chk_settle_exit_wdc: assert property (@(posedge clk_i) disable iff (rst_i) // [R01]
		s_settle_done |=> (in_run && watchdog_counter_clr_o))
		else $error("power-down wake without watchdog clear");
	chk_pd_bits_clear: assert property (@(posedge clk_i) disable iff (rst_i) // [R03] [R04]
		s_settle_done |=> (!pmc_q[`LPMC_BIT_PD] && !pmc_q[`LPMC_BIT_IDLE]))
		else $error("request bits kept after power-down wake");
	chk_idle_entry_stop: assert property (@(posedge clk_i) disable iff (rst_i) // [R08]
		s_idle_entry |=> !cpu_clk_en_o)
		else $error("instruction after idle request");
	chk_pd_entry_stop: assert property (@(posedge clk_i) disable iff (rst_i) // [R12]
		s_pd_entry |=> (!cpu_clk_en_o && !osc_run_o))
		else $error("instruction after power-down request");

	// Clock and freeze levels per state, and settle count
	chk_run_clk: assert property (@(posedge clk_i) disable iff (rst_i) // [R05]
		in_run |-> (cpu_clk_en_o && periph_clk_en_o && osc_run_o && !cpu_hold_o))
		else $error("run clocks wrong");
	chk_run_ports: assert property (@(posedge clk_i) disable iff (rst_i) // [R07]
		in_run |-> !port_freeze_o)
		else $error("ports frozen in run");
	chk_idle_freeze: assert property (@(posedge clk_i) disable iff (rst_i) // [R07]
		in_idle |-> (cpu_hold_o && port_freeze_o))
		else $error("idle does not freeze CPU");
	chk_pd_freeze: assert property (@(posedge clk_i) disable iff (rst_i) // [R12]
		in_pd |-> (cpu_hold_o && port_freeze_o))
		else $error("power-down does not freeze CPU");
	chk_settle_clk: assert property (@(posedge clk_i) disable iff (rst_i) // [R19]
		in_settle |-> (!cpu_clk_en_o && !periph_clk_en_o && osc_run_o && cpu_hold_o))
		else $error("settle clocks wrong");
	chk_settle_count: assert property (@(posedge clk_i) disable iff (rst_i) // [R19]
		(in_settle && !settled && !hw_reset_i) |=>
		(in_settle && settle_q == $past(settle_q) - 8'h01))
		else $error("settle count wrong");

	// Wake and exit sources
	chk_idle_stays: assert property (@(posedge clk_i) disable iff (rst_i) // [R09]
		(in_idle && !idle_wake && !hw_reset_i) |=> in_idle)
		else $error("idle left without interrupt");
	chk_idle_reset: assert property (@(posedge clk_i) disable iff (rst_i) // [R10]
		(in_idle && hw_reset_i) |=> in_run)
		else $error("reset did not end idle");
	chk_pd_reset: assert property (@(posedge clk_i) disable iff (rst_i) // [R13]
		(in_pd && hw_reset_i) |=> in_run)
		else $error("reset did not end power-down");
	chk_full_init_set: assert property (@(posedge clk_i) disable iff (rst_i) // [R14]
		full_init_reset_i |=> cpu_full_init_o)
		else $error("full init not requested");
	chk_full_init_clr: assert property (@(posedge clk_i) disable iff (rst_i) // [R14]
		!full_init_reset_i |=> !cpu_full_init_o)
		else $error("full init without reset");
	chk_ext_wake: assert property (@(posedge clk_i) disable iff (rst_i) // [R15]
		(in_pd && ext_wake && !hw_reset_i) |=> in_settle)
		else $error("enabled pin did not wake");
	chk_other_wake: assert property (@(posedge clk_i) disable iff (rst_i) // [R16]
		(in_pd && (supply_drop_irq_i || watchdog_irq_i) && !hw_reset_i) |=> in_settle)
		else $error("supply-drop or watchdog did not wake");
	chk_kp_wake: assert property (@(posedge clk_i) disable iff (rst_i) // [R17]
		(in_pd && kp_wake && !hw_reset_i) |=> in_settle)
		else $error("keypad edge did not wake");
	chk_kp_ref_hold: assert property (@(posedge clk_i) disable iff (rst_i) // [R17]
		in_pd |=> $stable(kp_ref_q))
		else $error("keypad entry level moved while asleep");

endmodule // lpmc_ctrl

// [dv/lpmc_wake_model.sv]
// Wake sources seen by the mode controller: interrupt logic and keypad pins.
// Assumes the bench selects one source at a time through fire_i.
`timescale 1ns/1ns

module lpmc_wake_model (
	input  wire logic       clk_i,
	input  wire logic [2:0] fire_i,
	output logic            pend_o,
	output logic [1:0]      pin_o,
	output logic            sdrop_o,
	output logic            wdog_o,
	output logic [7:0]      kbd_o
);
	initial begin
		pend_o = 1'h0;
		pin_o = 2'h0;
		sdrop_o = 1'h0;
		wdog_o = 1'h0;
		kbd_o = 8'h5b;
	end

	always @(posedge clk_i) begin
		pend_o <= (fire_i == 3'h1);
		pin_o <= {1'h0, fire_i == 3'h2};
		sdrop_o <= (fire_i == 3'h3);
		wdog_o <= (fire_i == 3'h4);
		// Pin 0 rests high, so only a fall may wake
		kbd_o <= (fire_i == 3'h5) ? 8'h5a : 8'h5b;
	end
endmodule // lpmc_wake_model

// [dv/low_power_mode_controller_tb_top.sv]
// Testbench for the low-power mode controller over classic Wishbone.
// Assumes the design, its package and defines file are compiled first.
`timescale 1ns/1ns
`include "lpmc_defs.svh"
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin failures++; \
	$display("MISMATCH %0t got %h exp %h", $time, a, e); end end

module low_power_mode_controller_tb_top;
	localparam logic [31:0] PMC = {22'h0, `LPMC_PMC_ADDR};
	logic        clk_i = 1'h0, rst_i = 1'h1, we = 1'h0, cyc = 1'h0, stb = 1'h0;
	logic        ge = 1'h0, hwr = 1'h0, fir = 1'h0;
	logic [31:0] adr = 32'h0, wd = 32'h0, rd, r;
	logic [3:0]  sel = 4'h0;
	logic [2:0]  fire = 3'h0;
	logic        ack, pend, sdr, wdg, cpu, per, osc, hold, wclr, frz, finit;
	logic [1:0]  pin;
	logic [7:0]  kbd;
	int          failures = 0, checks_done = 0, wdn = 0, w0, n;

	always #5 clk_i = ~clk_i;
	always @(posedge clk_i) if (wclr === 1'h1) wdn++;

	lpmc_ctrl i_lpmc_ctrl (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(wd),
		.wb_dat_o(rd), .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_ack_o(ack), .global_interrupt_enable_i(ge), .ext_int_en_i(2'h3),
		.ext_int_pin_i(pin), .enabled_irq_pending_i(pend), .supply_drop_irq_i(sdr),
		.watchdog_irq_i(wdg), .pin_change_keypad_en_i(1'h1), .pin_change_keypad_i(kbd),
		.hw_reset_i(hwr), .full_init_reset_i(fir), .cpu_clk_en_o(cpu),
		.periph_clk_en_o(per), .osc_run_o(osc), .cpu_hold_o(hold),
		.watchdog_counter_clr_o(wclr), .port_freeze_o(frz), .cpu_full_init_o(finit));

	lpmc_wake_model i_lpmc_wake_model (.clk_i(clk_i), .fire_i(fire), .pend_o(pend),
		.pin_o(pin), .sdrop_o(sdr), .wdog_o(wdg), .kbd_o(kbd));

	task automatic finish_test();
		if (failures == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic tick(input int c);
		repeat (c) @(posedge clk_i);
	endtask

	task automatic wb(input logic [31:0] a, input logic [31:0] d, input logic w,
		output logic [31:0] q);
		int t;
		t = 0;
		@(posedge clk_i);
		cyc <= 1'h1;
		stb <= 1'h1;
		we <= w;
		adr <= a;
		wd <= d;
		sel <= 4'hf;
		do begin
			@(posedge clk_i);
			t++;
		end while (ack !== 1'h1 && t < 50);
		q = rd;
		cyc <= 1'h0;
		stb <= 1'h0;
		we <= 1'h0;
		`CHK(t < 50, 1'h1)
	endtask

	task automatic wait_run(output int c);
		c = 0;
		while (cpu !== 1'h1 && c < 300) begin
			@(posedge clk_i);
			c++;
		end
		`CHK(c < 300, 1'h1)
	endtask

	initial begin
		tick(5000);
		failures++;
		finish_test();
	end

	initial begin
		tick(10);
		rst_i <= 1'h0;
		wb(PMC, 32'h0, 1'h0, r);
		`CHK(r, 32'h0)
		wb(32'h400, 32'hff, 1'h1, r);
		wb(32'h400, 32'h0, 1'h0, r);
		`CHK(r, 32'h0)
		w0 = wdn;
		wb(PMC, 32'h1, 1'h1, r);
		tick(2);
		`CHK({cpu, per, osc, hold, frz}, 5'h0f)
		`CHK(wdn, w0 + 1)
		fire <= 3'h1;
		wait_run(n);
		fire <= 3'h0;
		wb(PMC, 32'h0, 1'h0, r);
		`CHK(r, 32'h0)
		`CHK(wdn, w0 + 2)
		wb(PMC, 32'h1, 1'h1, r);
		tick(2);
		hwr <= 1'h1;
		tick(2);
		hwr <= 1'h0;
		wait_run(n);
		wb(PMC, 32'h2, 1'h1, r);
		tick(2);
		`CHK({cpu, per, osc, hold, frz}, 5'h03)
		wb(32'h220, 32'h0, 1'h0, r);
		`CHK(r, 32'ha)
		fire <= 3'h2;
		tick(20);
		`CHK(osc, 1'h0)
		ge <= 1'h1;
		tick(8);
		`CHK({cpu, per, osc, hold}, 4'h3)
		wait_run(n);
		`CHK(n > 85, 1'h1)
		fire <= 3'h0;
		wb(PMC, 32'h0, 1'h0, r);
		`CHK(r, 32'h0)
		for (int k = 3; k < 6; k++) begin
			w0 = wdn;
			wb(PMC, (k == 3) ? 32'h3 : 32'h2, 1'h1, r);
			tick(2);
			`CHK(osc, 1'h0)
			fire <= k[2:0];
			wait_run(n);
			fire <= 3'h0;
			tick(1);
			`CHK(cpu, 1'h1)
			`CHK(n > 98, 1'h1)
			wb(PMC, 32'h0, 1'h0, r);
			`CHK(r, 32'h0)
			`CHK(wdn, w0 + 2)
		end
		wb(PMC, 32'h2, 1'h1, r);
		tick(2);
		hwr <= 1'h1;
		fir <= 1'h1;
		tick(2);
		`CHK(finit, 1'h1)
		hwr <= 1'h0;
		fir <= 1'h0;
		wait_run(n);
		finish_test();
	end
endmodule // low_power_mode_controller_tb_top
